// [hdl/e1_rx_alarm_params.svh]
/*
  Offsets, field positions, thresholds and timing counts of the E1 receive
  alarm and status block. Assumes inclusion by bare name from the design.
*/
`ifndef E1_RX_ALARM_PARAMS_SVH
`define E1_RX_ALARM_PARAMS_SVH

// Register page and word addresses
`define STATUS_PAGE 8'h03
`define ADDR_ALARM_STATUS_ONE 5'h19
`define ADDR_SA6_CHANGE_REPORT 5'h1a
`define ADDR_DEVICE_IDENTITY 5'h1f

// Alarm status word one fields
`define BIT_SUBMF_ONE 7
`define BIT_SUBMF_TWO 6
`define BIT_REMOTE_FAIL 5
`define BIT_LOS 4
`define BIT_SLOT16 3
`define BIT_AIS 2
`define BIT_FAR_ALARM 1
`define BIT_FAR_CRC 0

// Sa6 report word fields
`define BIT_SA5 7
`define SA6_MSB 6
`define SA6_LSB 3
`define BIT_EIGHT_SAME 1
`define BIT_CHANGED 0

// Reset value of every status word
`define STATUS_RESET 8'h00

// Arbitrary neutral identity value
`define IDENTITY_DEFAULT 8'h3c

// Loss of signal
`define LOS_ZERO_RUN 7'd127
`define LOS_WINDOW 7'd127
`define LOS_EXIT_ONES 7'd16

// All-ones detection
`define AIS_PERIOD_LAST 9'd511
`define AIS_MAX_ZEROS 2'd2

// Remote generator failure
`define EBIT_THRESHOLD 10'd989
`define FAIL_SECONDS 3'd5
`define ONE_SECOND_NS 1000000000
`define MCLK_PERIOD_NS 25

// Sa6 nibble repetition
`define SA6_SAME_COUNT 4'd8

`endif

// [hdl/e1_rx_alarm_pkg.sv]
/*
  Types shared by the E1 receive alarm block: framer event carrier and
  Sa bit carrier. Assumes a framer delivering one-cycle event strobes.
*/
package e1_rx_alarm_pkg;

  // Framer events, each strobe one mclk cycle wide
  typedef struct packed {
    logic smf1_end;
    logic smf1_crc_err;
    logic smf2_end;
    logic smf2_crc_err;
    logic frame_end;
    logic slot16_ones;
    logic nfas_frame;
    logic a_bit;
    logic multiframe_end;
    logic crc_continuous;
  } rx_events_t;

  // Sa bits of one received nibble period
  typedef struct packed {
    logic strobe;
    logic sa5;
    logic [3:0] sa6;
  } sa_bits_t;

  typedef enum logic [1:0] {
    LOS_CLEAR,
    LOS_WAIT_PULSE,
    LOS_WINDOW
  } los_state_t;

endpackage

// [hdl/e1_receive_alarm_status.sv]
/*
  Receive-side alarm and status word bank of an E1 framer: CRC-4 submultiframe
  status, remote generator failure, loss of signal, all-ones alarms, remote
  alarm, Sa6 nibble monitor and identity word.
  Assumes line bits and framer event strobes synchronous to mclk, and a
  register read strobe of one cycle per access.
*/
`timescale 1ns/1ps
`include "e1_rx_alarm_params.svh"

// Summary of operation
// - Submultiframe 1 end updates first CRC flag
// - Submultiframe 2 end updates second CRC flag
// - Five bad E-bit seconds raise generator failure
// - 127 zero bits declare loss of signal
// - 127-bit window from pulse, 12.5% ends LOS
// - Each frame updates slot sixteen all-ones bit
// - All-ones alarm follows selected detection criterion
// - Each NFAS frame copies A bit
// - Each multiframe updates alarm-with-CRC-errors bit
// - Eighth same nibble sets flag, latches Sa
// - Differing Sa6 nibble sets change flag
// - Reading Sa6 report clears its contents
// - Fixed identity word at address 1FH
module e1_receive_alarm_status
  import e1_rx_alarm_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = `ONE_SECOND_NS / `MCLK_PERIOD_NS,
  parameter logic [7:0] IDENTITY = `IDENTITY_DEFAULT
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Received line bits
  input wire logic line_bit_valid,
  input wire logic line_bit,
  // Framer events
  input wire rx_events_t rx_events,
  input wire sa_bits_t sa_bits,
  input wire logic ebit_error,
  input wire logic basic_sync_lost,
  // Control
  input wire logic alarm_criterion_select,
  // Register port and loss of signal output
  input wire logic [7:0] reg_page,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic loss_of_signal
);

  localparam int unsigned SEC_W = $clog2(SECOND_CYCLES + 1);

  // Frame-driven status bits
  logic submf_one_check_fail, next_submf_one_check_fail;
  logic submf_two_check_fail, next_submf_two_check_fail;
  logic slot_sixteen_all_ones, next_slot_sixteen_all_ones;
  logic far_end_alarm_status, next_far_end_alarm_status;
  logic far_alarm_with_check_errors, next_far_alarm_with_check_errors;

  always_comb
  begin
    next_submf_one_check_fail = submf_one_check_fail;
    next_submf_two_check_fail = submf_two_check_fail;
    next_slot_sixteen_all_ones = slot_sixteen_all_ones;
    next_far_end_alarm_status = far_end_alarm_status;
    next_far_alarm_with_check_errors = far_alarm_with_check_errors;
    if (rx_events.smf1_end)
      next_submf_one_check_fail = rx_events.smf1_crc_err;
    if (rx_events.smf2_end)
      next_submf_two_check_fail = rx_events.smf2_crc_err;
    if (rx_events.frame_end)
      next_slot_sixteen_all_ones = rx_events.slot16_ones;
    if (rx_events.nfas_frame)
      next_far_end_alarm_status = rx_events.a_bit;
    if (rx_events.multiframe_end)
      next_far_alarm_with_check_errors = far_end_alarm_status & rx_events.crc_continuous;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      submf_one_check_fail <= 1'b0;
      submf_two_check_fail <= 1'b0;
      slot_sixteen_all_ones <= 1'b0;
      far_end_alarm_status <= 1'b0;
      far_alarm_with_check_errors <= 1'b0;
    end
    else
    begin
      submf_one_check_fail <= next_submf_one_check_fail;
      submf_two_check_fail <= next_submf_two_check_fail;
      slot_sixteen_all_ones <= next_slot_sixteen_all_ones;
      far_end_alarm_status <= next_far_end_alarm_status;
      far_alarm_with_check_errors <= next_far_alarm_with_check_errors;
    end
  end

  // Loss of signal monitor
  los_state_t los_state, next_los_state;
  logic [6:0] zero_run, next_zero_run;
  logic [6:0] win_pos, next_win_pos;
  logic [6:0] win_ones, next_win_ones;
  logic next_loss_of_signal;

  always_comb
  begin
    next_los_state = los_state;
    next_zero_run = zero_run;
    next_win_pos = win_pos;
    next_win_ones = win_ones;
    next_loss_of_signal = loss_of_signal;
    if (line_bit_valid)
    begin
      next_zero_run = line_bit ? 7'd0 :
        (zero_run == `LOS_ZERO_RUN) ? zero_run : zero_run + 7'd1;
      unique case (los_state)
        LOS_CLEAR:
        begin
          if (!line_bit && zero_run == `LOS_ZERO_RUN - 7'd1)
          begin
            next_loss_of_signal = 1'b1;
            next_los_state = LOS_WAIT_PULSE;
          end
        end
        LOS_WAIT_PULSE:
        begin
          if (line_bit)
          begin
            next_win_pos = 7'd1;
            next_win_ones = 7'd1;
            next_los_state = LOS_WINDOW;
          end
        end
        LOS_WINDOW:
        begin
          next_win_pos = win_pos + 7'd1;
          next_win_ones = win_ones + {6'd0, line_bit};
          if (win_pos == `LOS_WINDOW - 7'd1)
          begin
            if (win_ones + {6'd0, line_bit} >= `LOS_EXIT_ONES)
            begin
              next_loss_of_signal = 1'b0;
              next_los_state = LOS_CLEAR;
            end
            else
              next_los_state = LOS_WAIT_PULSE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      los_state <= LOS_CLEAR;
      zero_run <= 7'd0;
      win_pos <= 7'd0;
      win_ones <= 7'd0;
      loss_of_signal <= 1'b0;
    end
    else
    begin
      los_state <= next_los_state;
      zero_run <= next_zero_run;
      win_pos <= next_win_pos;
      win_ones <= next_win_ones;
      loss_of_signal <= next_loss_of_signal;
    end
  end

  // All-ones detector over 512-bit periods
  logic [8:0] ais_bits, next_ais_bits;
  logic [1:0] ais_zeros, next_ais_zeros;
  logic ais_prev_ok, next_ais_prev_ok;
  logic all_ones_alarm_status, next_all_ones_alarm_status;
  logic period_ok;

  always_comb
  begin
    next_ais_bits = ais_bits;
    next_ais_zeros = ais_zeros;
    next_ais_prev_ok = ais_prev_ok;
    next_all_ones_alarm_status = all_ones_alarm_status;
    period_ok = (ais_zeros + {1'b0, ~line_bit}) <= `AIS_MAX_ZEROS && !(ais_zeros == 2'd3);
    if (line_bit_valid)
    begin
      next_ais_bits = ais_bits + 9'd1;
      if (!line_bit && ais_zeros != 2'd3)
        next_ais_zeros = ais_zeros + 2'd1;
      if (ais_bits == `AIS_PERIOD_LAST)
      begin
        next_ais_zeros = 2'd0;
        next_ais_prev_ok = period_ok;
        // One period, or two in a row when selected
        next_all_ones_alarm_status = alarm_criterion_select ? (period_ok & ais_prev_ok)
                                                            : period_ok;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ais_bits <= 9'd0;
      ais_zeros <= 2'd0;
      ais_prev_ok <= 1'b0;
      all_ones_alarm_status <= 1'b0;
    end
    else
    begin
      ais_bits <= next_ais_bits;
      ais_zeros <= next_ais_zeros;
      ais_prev_ok <= next_ais_prev_ok;
      all_ones_alarm_status <= next_all_ones_alarm_status;
    end
  end

  // Remote generator failure over one-second enables
  logic [SEC_W-1:0] sec_cnt, next_sec_cnt;
  logic [9:0] ebit_cnt, next_ebit_cnt;
  logic sec_bad, next_sec_bad;
  logic [2:0] bad_secs, next_bad_secs;
  logic remote_generator_failure, next_remote_generator_failure;
  logic second_tick;
  logic second_hit;

  always_comb
  begin
    second_tick = (sec_cnt == SEC_W'(SECOND_CYCLES - 1));
    next_sec_cnt = second_tick ? '0 : sec_cnt + SEC_W'(1);
    next_ebit_cnt = (ebit_error && ebit_cnt != 10'h3ff) ? ebit_cnt + 10'd1 : ebit_cnt;
    next_sec_bad = sec_bad | far_end_alarm_status | basic_sync_lost;
    next_bad_secs = bad_secs;
    next_remote_generator_failure = remote_generator_failure;
    second_hit = (next_ebit_cnt > `EBIT_THRESHOLD) && !next_sec_bad;
    if (second_tick)
    begin
      next_ebit_cnt = 10'd0;
      next_sec_bad = 1'b0;
      // Five qualifying seconds in a row
      if (!second_hit)
        next_bad_secs = 3'd0;
      else if (bad_secs != `FAIL_SECONDS)
        next_bad_secs = bad_secs + 3'd1;
      next_remote_generator_failure = second_hit && (bad_secs >= `FAIL_SECONDS - 3'd1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_cnt <= '0;
      ebit_cnt <= 10'd0;
      sec_bad <= 1'b0;
      bad_secs <= 3'd0;
      remote_generator_failure <= 1'b0;
    end
    else
    begin
      sec_cnt <= next_sec_cnt;
      ebit_cnt <= next_ebit_cnt;
      sec_bad <= next_sec_bad;
      bad_secs <= next_bad_secs;
      remote_generator_failure <= next_remote_generator_failure;
    end
  end

  // Sa6 nibble monitor and report word
  logic [3:0] prev_sa6, next_prev_sa6;
  logic have_prev, next_have_prev;
  logic [3:0] same_cnt, next_same_cnt;
  logic latched_sa5, next_latched_sa5;
  logic [3:0] latched_sa6, next_latched_sa6;
  logic eight_same_nibbles, next_eight_same_nibbles;
  logic nibble_changed, next_nibble_changed;
  logic status_read;
  logic report_read;

  always_comb
  begin
    status_read = reg_rd && reg_page == `STATUS_PAGE;
    report_read = status_read && reg_addr == `ADDR_SA6_CHANGE_REPORT;
    next_prev_sa6 = prev_sa6;
    next_have_prev = have_prev;
    next_same_cnt = same_cnt;
    next_latched_sa5 = latched_sa5;
    next_latched_sa6 = latched_sa6;
    next_eight_same_nibbles = eight_same_nibbles;
    next_nibble_changed = nibble_changed;
    // Read clears, a same-cycle event still sets
    if (report_read)
    begin
      next_latched_sa5 = 1'b0;
      next_latched_sa6 = 4'd0;
      next_eight_same_nibbles = 1'b0;
      next_nibble_changed = 1'b0;
    end
    if (sa_bits.strobe)
    begin
      next_prev_sa6 = sa_bits.sa6;
      next_have_prev = 1'b1;
      if (have_prev && sa_bits.sa6 != prev_sa6)
      begin
        next_nibble_changed = 1'b1;
        next_same_cnt = 4'd1;
      end
      else if (!have_prev)
        next_same_cnt = 4'd1;
      else if (same_cnt != `SA6_SAME_COUNT)
      begin
        next_same_cnt = same_cnt + 4'd1;
        if (same_cnt == `SA6_SAME_COUNT - 4'd1)
        begin
          next_eight_same_nibbles = 1'b1;
          next_latched_sa5 = sa_bits.sa5;
          next_latched_sa6 = sa_bits.sa6;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_sa6 <= 4'd0;
      have_prev <= 1'b0;
      same_cnt <= 4'd0;
      latched_sa5 <= 1'b0;
      latched_sa6 <= 4'd0;
      eight_same_nibbles <= 1'b0;
      nibble_changed <= 1'b0;
    end
    else
    begin
      prev_sa6 <= next_prev_sa6;
      have_prev <= next_have_prev;
      same_cnt <= next_same_cnt;
      latched_sa5 <= next_latched_sa5;
      latched_sa6 <= next_latched_sa6;
      eight_same_nibbles <= next_eight_same_nibbles;
      nibble_changed <= next_nibble_changed;
    end
  end

  // Read data, captured on the read strobe
  logic [7:0] next_reg_rdata;
  logic [7:0] alarm_status_one;
  logic [7:0] sa6_change_report;

  always_comb
  begin
    alarm_status_one = `STATUS_RESET;
    alarm_status_one[`BIT_SUBMF_ONE] = submf_one_check_fail;
    alarm_status_one[`BIT_SUBMF_TWO] = submf_two_check_fail;
    alarm_status_one[`BIT_REMOTE_FAIL] = remote_generator_failure;
    alarm_status_one[`BIT_LOS] = loss_of_signal;
    alarm_status_one[`BIT_SLOT16] = slot_sixteen_all_ones;
    alarm_status_one[`BIT_AIS] = all_ones_alarm_status;
    alarm_status_one[`BIT_FAR_ALARM] = far_end_alarm_status;
    alarm_status_one[`BIT_FAR_CRC] = far_alarm_with_check_errors;
    sa6_change_report = `STATUS_RESET;
    sa6_change_report[`BIT_SA5] = latched_sa5;
    sa6_change_report[`SA6_MSB:`SA6_LSB] = latched_sa6;
    sa6_change_report[`BIT_EIGHT_SAME] = eight_same_nibbles;
    sa6_change_report[`BIT_CHANGED] = nibble_changed;
    next_reg_rdata = reg_rdata;
    if (status_read)
    begin
      // Reads leave alarm status untouched; a Sa6 report read clears the report word
      unique case (reg_addr)
        `ADDR_ALARM_STATUS_ONE: next_reg_rdata = alarm_status_one;
        `ADDR_SA6_CHANGE_REPORT: next_reg_rdata = sa6_change_report;
        `ADDR_DEVICE_IDENTITY: next_reg_rdata = IDENTITY;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_reg_rdata;
  end

endmodule // e1_receive_alarm_status

// [test/far_end_line.sv]
/*
  Far-end line model: one line bit every second mclk, a one every ones_gap
  bits, all zeros for gap 0. Assumes the bench sets ones_gap.
*/
`timescale 1ns/1ps
module far_end_line (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pattern control
  input wire logic [3:0] ones_gap,
  // Line side
  output logic line_bit_valid,
  output logic line_bit
);
  logic [3:0] pos;
  logic [3:0] gap_seen;
  logic [3:0] cur;
  // New pattern restarts with a one
  assign cur = (gap_seen != ones_gap) ? 4'h0 : pos;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_bit_valid <= 1'b0;
      line_bit <= 1'b0;
      pos <= 4'h0;
      gap_seen <= 4'h0;
    end
    else
    begin
      line_bit_valid <= !line_bit_valid;
      // Junk between bit periods
      if (line_bit_valid)
        line_bit <= !line_bit;
      else
      begin
        gap_seen <= ones_gap;
        line_bit <= (ones_gap != 4'h0) && (cur == 4'h0);
        pos <= (cur + 4'h1 >= ones_gap) ? 4'h0 : cur + 4'h1;
      end
    end
  end
endmodule // far_end_line

// [test/e1_receive_alarm_status_assertions.sv]
/*
  Port checker of the E1 receive alarm block.
  Assumes binding to the design top; read data lands one cycle late.
*/
`timescale 1ns/1ps
module e1_receive_alarm_status_assertions
  import e1_rx_alarm_pkg::*;
#(
  parameter logic [7:0] IDENTITY = 8'h3c
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched inputs
  input wire logic line_bit_valid,
  input wire logic line_bit,
  input wire rx_events_t rx_events,
  input wire sa_bits_t sa_bits,
  input wire logic [7:0] reg_page,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  // Watched outputs
  input wire logic [7:0] reg_rdata,
  input wire logic loss_of_signal
);
  logic [6:0] zero_run;
  logic rd_st;
  logic rd_rep;
  assign rd_st = reg_rd && reg_page == 8'h03 && reg_addr == 5'h19;
  assign rd_rep = reg_rd && reg_page == 8'h03 && reg_addr == 5'h1a;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Run of zero line bits
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      zero_run <= 7'h00;
    else if (line_bit_valid)
      zero_run <= line_bit ? 7'h00 : (zero_run == 7'h7f ? zero_run : zero_run + 7'h01);
  end
  id_word_a: assert property (
    reg_rd && reg_page == 8'h03 && reg_addr == 5'h1f |=> reg_rdata == IDENTITY)
    else $error("identity word wrong");
  unmapped_read_a: assert property (
    reg_rd && reg_page == 8'h03 && !(reg_addr inside {5'h19, 5'h1a, 5'h1f})
    |=> reg_rdata == 8'h00) else $error("unmapped word not zero");
  other_page_a: assert property (
    reg_rd && reg_page != 8'h03 |=> $stable(reg_rdata)) else $error("other page changed data");
  los_mirror_a: assert property (
    rd_st |=> reg_rdata[4] == $past(loss_of_signal)) else $error("status bit 4 differs");
  submf_one_a: assert property (
    rx_events.smf1_end ##1 rd_st |=> reg_rdata[7] == $past(rx_events.smf1_crc_err, 2))
    else $error("first check flag wrong");
  far_alarm_a: assert property (
    rx_events.nfas_frame ##1 rd_st |=> reg_rdata[1] == $past(rx_events.a_bit, 2))
    else $error("far-end alarm bit wrong");
  los_entry_a: assert property (
    line_bit_valid && !line_bit && zero_run == 7'd126 |=> loss_of_signal)
    else $error("no loss of signal after zero run");
  report_clear_a: assert property (
    rd_rep && !sa_bits.strobe ##1 rd_rep && !sa_bits.strobe |=> reg_rdata == 8'h00)
    else $error("report word not cleared");
endmodule // e1_receive_alarm_status_assertions

bind e1_receive_alarm_status e1_receive_alarm_status_assertions #(.IDENTITY(IDENTITY)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .line_bit_valid(line_bit_valid), .line_bit(line_bit),
  .rx_events(rx_events), .sa_bits(sa_bits), .reg_page(reg_page), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loss_of_signal(loss_of_signal));

// [test/e1_receive_alarm_status_tb.sv]
/*
  Self-checking bench of the E1 receive alarm block: event rows, then loss of
  signal, all-ones alarm, Sa6 monitor, generator failure and register map.
  Assumes the far-end line model beside the design.
*/
`timescale 1ns/1ps
module e1_receive_alarm_status_tb;
  import e1_rx_alarm_pkg::*;
  // Arbitrary identity value
  localparam logic [7:0] ID_TB = 8'h5b;
  localparam int SEC = 1024;
  typedef struct {
    rx_events_t ev;
    logic [7:0] mask;
    logic [7:0] want;
  } row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic line_bit_valid;
  logic line_bit;
  rx_events_t rx_events = '0;
  sa_bits_t sa_bits = '0;
  logic ebit_error = 1'b0;
  logic basic_sync_lost = 1'b0;
  logic sel = 1'b0;
  logic [7:0] reg_page = 8'h03;
  logic [4:0] reg_addr = 5'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic loss_of_signal;
  logic [3:0] ones_gap = 4'h1;
  logic [7:0] first;
  int n_errors = 0;
  int checks_done = 0;
  row_t rows[10] = '{'{10'h300, 8'h80, 8'h80}, '{10'h200, 8'h80, 8'h00},
    '{10'h0c0, 8'h40, 8'h40}, '{10'h080, 8'h40, 8'h00}, '{10'h030, 8'h08, 8'h08},
    '{10'h020, 8'h08, 8'h00}, '{10'h00c, 8'h02, 8'h02}, '{10'h003, 8'h01, 8'h01},
    '{10'h008, 8'h02, 8'h00}, '{10'h003, 8'h01, 8'h00}};
  always #12.5 mclk = ~mclk;
  e1_receive_alarm_status #(.SECOND_CYCLES(SEC), .IDENTITY(ID_TB)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .line_bit_valid(line_bit_valid), .line_bit(line_bit),
    .rx_events(rx_events), .sa_bits(sa_bits), .ebit_error(ebit_error),
    .basic_sync_lost(basic_sync_lost), .alarm_criterion_select(sel), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .loss_of_signal(loss_of_signal));
  far_end_line u_far (.mclk(mclk), .rst_n(rst_n), .ones_gap(ones_gap),
    .line_bit_valid(line_bit_valid), .line_bit(line_bit));
  task chk(input string what, input logic [7:0] want, input logic [7:0] got);
    checks_done++;
    if (got !== want)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask
  // Back-to-back reads from a falling edge
  task rd(input logic [4:0] a, input int n);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    first = reg_rdata;
    repeat (n - 1) @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
  endtask
  task sa(input logic s5, input logic [3:0] nib, input int n);
    repeat (n)
    begin
      sa_bits = {1'b1, s5, nib};
      @(negedge mclk);
      sa_bits = '0;
      @(negedge mclk);
    end
  endtask
  task bits(input int n);
    repeat (2 * n) @(negedge mclk);
  endtask
  task summarize;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #750000;
    n_errors++;
    summarize;
  end
  initial
  begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    chk("rdata", 8'h00, reg_rdata);
    rd(5'h19, 1);
    chk("status", 8'h00, first);
    foreach (rows[i])
    begin
      rx_events = rows[i].ev;
      @(negedge mclk);
      rx_events = '0;
      rd(5'h19, 2);
      chk("status", rows[i].want, first & rows[i].mask);
      chk("reread", rows[i].want, reg_rdata & rows[i].mask);
    end
    ones_gap = 4'h0;
    bits(130);
    chk("los", 8'h01, {7'h00, loss_of_signal});
    ones_gap = 4'h9;
    bits(300);
    chk("los thin", 8'h01, {7'h00, loss_of_signal});
    ones_gap = 4'h8;
    bits(280);
    rd(5'h19, 1);
    chk("los exit", 8'h00, first & 8'h10);
    ones_gap = 4'h1;
    bits(1100);
    rd(5'h19, 1);
    chk("ais one", 8'h04, first & 8'h04);
    sel = 1'b1;
    ones_gap = 4'h4;
    bits(1100);
    ones_gap = 4'h1;
    bits(600);
    rd(5'h19, 1);
    chk("ais two", 8'h00, first & 8'h04);
    bits(1100);
    rd(5'h19, 1);
    chk("ais two", 8'h04, first & 8'h04);
    sa(1'b1, 4'ha, 8);
    rd(5'h1a, 2);
    chk("sa report", 8'hd2, first);
    chk("sa cleared", 8'h00, reg_rdata);
    sa(1'b0, 4'h5, 7);
    rd(5'h1a, 1);
    chk("sa change", 8'h01, first);
    sa(1'b0, 4'h5, 1);
    rd(5'h1a, 1);
    chk("sa relatch", 8'h2a, first);
    ebit_error = 1'b1;
    repeat (6 * SEC + 100) @(negedge mclk);
    rd(5'h19, 1);
    chk("gen fail", 8'h20, first & 8'h20);
    basic_sync_lost = 1'b1;
    @(negedge mclk);
    basic_sync_lost = 1'b0;
    repeat (SEC + 50) @(negedge mclk);
    rd(5'h19, 1);
    chk("gen fail", 8'h00, first & 8'h20);
    rd(5'h1b, 1);
    chk("unmapped", 8'h00, first);
    rd(5'h1f, 1);
    chk("identity", ID_TB, first);
    // Other page must leave the identity word standing
    reg_page = 8'h04;
    rd(5'h1b, 1);
    chk("other page", ID_TB, first);
    reg_page = 8'h03;
    // Mid-run reset returns read data, loss of signal and alarm status word one to zero
    rst_n = 1'b0;
    @(negedge mclk);
    chk("reset rdata", 8'h00, reg_rdata);
    chk("reset los", 8'h00, {7'h00, loss_of_signal});
    rst_n = 1'b1;
    rd(5'h19, 1);
    chk("reset status", 8'h00, first);
    summarize;
  end
endmodule // e1_receive_alarm_status_tb
